// ### rtl/flash_cmd_pkg.sv
// package: command codes, addresses, timing and carriers for the flash host controller
package flash_cmd_pkg;
	localparam logic [10:0] UNLOCK_ADDR_A = 11'h555;
	localparam logic [10:0] UNLOCK_ADDR_B = 11'h2AA;
	localparam logic [10:0] QUERY_ADDR = 11'h055;
	localparam logic [7:0] UNLOCK_DATA_A = 8'hAA;
	localparam logic [7:0] UNLOCK_DATA_B = 8'h55;
	localparam logic [7:0] CMD_RESET = 8'hF0;
	localparam logic [7:0] CMD_IDENT = 8'h90;
	localparam logic [7:0] CMD_REGION = 8'h88;
	localparam logic [7:0] CMD_PROGRAM = 8'hA0;
	localparam logic [7:0] CMD_BUF_LOAD = 8'h25;
	localparam logic [7:0] CMD_BUF_COMMIT = 8'h29;
	localparam logic [7:0] CMD_BYPASS = 8'h20;
	localparam logic [7:0] CMD_EXIT = 8'h00;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
	localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
	localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
	localparam logic [7:0] CMD_SUSPEND = 8'hB0;
	localparam logic [7:0] CMD_RESUME = 8'h30;
	localparam logic [7:0] CMD_QUERY = 8'h98;
	// identification offsets
	localparam logic [7:0] ID_MAKER = 8'h00;
	localparam logic [7:0] ID_DEV1 = 8'h01;
	localparam logic [7:0] ID_PROT = 8'h02;
	localparam logic [7:0] ID_LOCK = 8'h03;
	localparam logic [7:0] ID_DEV2 = 8'h0E;
	localparam logic [7:0] ID_DEV3 = 8'h0F;
	// status bit positions, sector address LSB and buffer limits
	localparam int TOGGLE_TWO_POS = 2;
	localparam int ERASE_WINDOW_POS = 3;
	localparam int TIMEOUT_ERR_POS = 5;
	localparam int TOGGLE_ONE_POS = 6;
	localparam int POLLING_POS = 7;
	localparam int SECTOR_LSB = 15;
	localparam int MAX_BUF_WORDS = 16;
	localparam int MAX_BUF_CYCLES = 21;
	// bus timing, cycles of the 100 MHz clock
	localparam int CLK_PERIOD_NS = 10;
	localparam int STROBE_NS = 50;
	localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACCESS_NS = 100;
	localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ERASE_WINDOW_US = 50;
	localparam int ERASE_WINDOW_CYC = ERASE_WINDOW_US * 1000 / CLK_PERIOD_NS;

	typedef enum logic [3:0] {
		OP_READ,
		OP_RESET,
		OP_IDENT,
		OP_REGION_ENTER,
		OP_REGION_EXIT,
		OP_PROGRAM,
		OP_BUF_PROGRAM,
		OP_BUF_ABORT,
		OP_BYPASS_ENTER,
		OP_BYPASS_PROGRAM,
		OP_BYPASS_EXIT,
		OP_CHIP_ERASE,
		OP_SECTOR_ERASE,
		OP_SUSPEND,
		OP_RESUME,
		OP_QUERY
	} op_t;

	typedef struct packed {
		logic [21:0] addr;
		logic [15:0] data;
	} cycle_t;

	typedef struct packed {
		logic timeout_error_bit;
		logic polling_bit;
		logic toggle_bit_one;
		logic toggle_bit_two;
		logic erase_window_bit;
	} status_t;
endpackage

// ### rtl/flash_host_ctrl.sv
// host controller that issues command sequences to the parallel flash pins
module flash_host_ctrl #(
	parameter int ADDR_W = 22,
	parameter int DATA_W = 16,
	parameter int COUNT_W = 5,
	parameter int ERASE_WINDOW_CYCLES = flash_cmd_pkg::ERASE_WINDOW_CYC
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// user command port
	input wire logic cmd_valid_i,
	output logic cmd_ready_o,
	input wire flash_cmd_pkg::op_t cmd_op_i,
	input wire logic [ADDR_W-1:0] cmd_addr_i,
	input wire logic [DATA_W-1:0] cmd_data_i,
	input wire logic [COUNT_W-1:0] cmd_count_i,
	input wire logic cmd_in_bypass_i,
	// buffered program words
	output logic buf_word_req_o,
	input wire logic [ADDR_W-1:0] buf_addr_i,
	input wire logic [DATA_W-1:0] buf_data_i,
	// user answer port
	output logic rsp_valid_o,
	output logic [DATA_W-1:0] rsp_data_o,
	output flash_cmd_pkg::status_t rsp_status_o,
	output logic device_busy_o,
	output logic erase_window_open_o,
	// flash pins
	output logic [ADDR_W-1:0] flash_addr_o,
	input wire logic [DATA_W-1:0] flash_dq_i,
	output logic [DATA_W-1:0] flash_dq_o,
	output logic flash_dq_oe_o,
	output logic flash_ce_n_o,
	output logic flash_we_n_o,
	output logic flash_oe_n_o,
	input wire logic ready_busy_out_i
);
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SETUP,
		ST_STROBE,
		ST_HOLD,
		ST_READ,
		ST_DONE
	} state_t;

	typedef struct packed {
		state_t st;
		logic [4:0] step;
		logic [4:0] last;
		logic [3:0] tick;
		logic is_read;
		flash_cmd_pkg::op_t op;
		logic [ADDR_W-1:0] base;
		logic [DATA_W-1:0] wdata;
		logic [COUNT_W-1:0] count;
		flash_cmd_pkg::cycle_t cur;
		logic [DATA_W-1:0] rdata;
		logic rvalid;
		logic [31:0] win;
		logic byp;
		logic [ADDR_W-1:0] page;
	} ctrl_t;

	ctrl_t r;
	ctrl_t next_r;

	// unlock-style write: only low 11 address bits, low data byte matter
	function automatic flash_cmd_pkg::cycle_t cmd_cyc(input logic [10:0] a, input logic [7:0] d);
		cmd_cyc.addr = {11'h000, a};
		cmd_cyc.data = {8'h00, d};
	endfunction

	function automatic flash_cmd_pkg::cycle_t raw_cyc(input logic [21:0] a, input logic [15:0] d);
		raw_cyc.addr = a;
		raw_cyc.data = d;
	endfunction

	// the two erase operations repeat the unlock pair after the setup write
	function automatic logic is_erase_op(input flash_cmd_pkg::op_t op);
		is_erase_op = op == flash_cmd_pkg::OP_CHIP_ERASE ||
			op == flash_cmd_pkg::OP_SECTOR_ERASE;
	endfunction

	// number of bus cycles of each operation, read included where one ends it
	function automatic logic [4:0] seq_len(input flash_cmd_pkg::op_t op, input logic [4:0] cnt,
		input logic byp);
		unique case (op)
			flash_cmd_pkg::OP_READ, flash_cmd_pkg::OP_RESET, flash_cmd_pkg::OP_SUSPEND,
			flash_cmd_pkg::OP_RESUME, flash_cmd_pkg::OP_QUERY: seq_len = 5'h01;
			flash_cmd_pkg::OP_IDENT, flash_cmd_pkg::OP_REGION_EXIT: seq_len = 5'h04;
			flash_cmd_pkg::OP_REGION_ENTER, flash_cmd_pkg::OP_BUF_ABORT,
			flash_cmd_pkg::OP_BYPASS_ENTER: seq_len = 5'h03;
			flash_cmd_pkg::OP_PROGRAM: seq_len = byp ? 5'h02 : 5'h04;
			flash_cmd_pkg::OP_BYPASS_PROGRAM, flash_cmd_pkg::OP_BYPASS_EXIT: seq_len = 5'h02;
			flash_cmd_pkg::OP_BUF_PROGRAM: seq_len = 5'h05 + cnt + 5'h01;
			default: seq_len = 5'h06;
		endcase
	endfunction

	// count clipped so a buffered sequence never passes its cycle limit
	logic [4:0] cnt_clip;
	assign cnt_clip = (r.count > COUNT_W'(flash_cmd_pkg::MAX_BUF_WORDS - 1)) ?
		5'(flash_cmd_pkg::MAX_BUF_WORDS - 1) : 5'(r.count);

	// erase repeats the unlock pair at steps 3 and 4; other ops go on after step 2
	logic unlock_a_step;
	logic unlock_b_step;
	assign unlock_a_step = r.step == 5'h00 || (is_erase_op(r.op) && r.step == 5'h03);
	assign unlock_b_step = r.step == 5'h01 || (is_erase_op(r.op) && r.step == 5'h04);

	// later buffer words keep the page of the first word
	localparam int PAGE_BITS = $clog2(flash_cmd_pkg::MAX_BUF_WORDS);
	logic [ADDR_W-1:0] page_addr;
	assign page_addr = {r.page[ADDR_W-1:PAGE_BITS], buf_addr_i[PAGE_BITS-1:0]};

	// the bus cycle for the current step
	flash_cmd_pkg::cycle_t step_cyc;
	logic step_is_read;
	always_comb begin
		step_cyc = raw_cyc(22'(r.base), 16'(r.wdata));
		step_is_read = 1'b0;
		unique case (r.op)
			flash_cmd_pkg::OP_READ: begin
				step_is_read = 1'b1;
			end
			flash_cmd_pkg::OP_RESET: step_cyc = cmd_cyc(11'h000, flash_cmd_pkg::CMD_RESET);
			flash_cmd_pkg::OP_SUSPEND: step_cyc = cmd_cyc(11'h000, flash_cmd_pkg::CMD_SUSPEND);
			flash_cmd_pkg::OP_RESUME: step_cyc = cmd_cyc(11'h000, flash_cmd_pkg::CMD_RESUME);
			flash_cmd_pkg::OP_QUERY: step_cyc = cmd_cyc(flash_cmd_pkg::QUERY_ADDR,
				flash_cmd_pkg::CMD_QUERY);
			flash_cmd_pkg::OP_BYPASS_PROGRAM: begin
				if (r.step == 5'h00) step_cyc = cmd_cyc(11'h000, flash_cmd_pkg::CMD_PROGRAM);
			end
			flash_cmd_pkg::OP_BYPASS_EXIT: begin
				step_cyc = cmd_cyc(11'h000, (r.step == 5'h00) ? flash_cmd_pkg::CMD_IDENT :
					flash_cmd_pkg::CMD_EXIT);
			end
			default: begin
				if (r.op == flash_cmd_pkg::OP_PROGRAM && r.byp) begin
					if (r.step == 5'h00) step_cyc = cmd_cyc(11'h000, flash_cmd_pkg::CMD_PROGRAM);
				end else if (unlock_a_step) begin
					step_cyc = cmd_cyc(flash_cmd_pkg::UNLOCK_ADDR_A, flash_cmd_pkg::UNLOCK_DATA_A);
				end else if (unlock_b_step) begin
					step_cyc = cmd_cyc(flash_cmd_pkg::UNLOCK_ADDR_B, flash_cmd_pkg::UNLOCK_DATA_B);
				end else if (r.step == 5'h02) begin
					unique case (r.op)
						flash_cmd_pkg::OP_IDENT, flash_cmd_pkg::OP_REGION_EXIT:
							step_cyc = cmd_cyc(flash_cmd_pkg::UNLOCK_ADDR_A,
								flash_cmd_pkg::CMD_IDENT);
						flash_cmd_pkg::OP_REGION_ENTER: step_cyc = cmd_cyc(
							flash_cmd_pkg::UNLOCK_ADDR_A, flash_cmd_pkg::CMD_REGION);
						flash_cmd_pkg::OP_PROGRAM: step_cyc = cmd_cyc(flash_cmd_pkg::UNLOCK_ADDR_A,
							flash_cmd_pkg::CMD_PROGRAM);
						flash_cmd_pkg::OP_BUF_PROGRAM: step_cyc = raw_cyc(22'(r.base),
							{8'h00, flash_cmd_pkg::CMD_BUF_LOAD});
						flash_cmd_pkg::OP_BUF_ABORT: step_cyc = cmd_cyc(flash_cmd_pkg::UNLOCK_ADDR_A,
							flash_cmd_pkg::CMD_RESET);
						flash_cmd_pkg::OP_BYPASS_ENTER: step_cyc = cmd_cyc(
							flash_cmd_pkg::UNLOCK_ADDR_A, flash_cmd_pkg::CMD_BYPASS);
						default: step_cyc = cmd_cyc(flash_cmd_pkg::UNLOCK_ADDR_A,
							flash_cmd_pkg::CMD_ERASE_SETUP);
					endcase
				end else if (r.op == flash_cmd_pkg::OP_IDENT) begin
					step_cyc = raw_cyc(22'(r.base), 16'h0000);
					step_is_read = 1'b1;
				end else if (r.op == flash_cmd_pkg::OP_REGION_EXIT) begin
					step_cyc = cmd_cyc(11'h000, flash_cmd_pkg::CMD_EXIT);
				end else if (r.op == flash_cmd_pkg::OP_BUF_PROGRAM) begin
					if (r.step == 5'h03) begin
						step_cyc = raw_cyc(22'(r.base), 16'(cnt_clip));
					end else if (r.step == r.last - 5'h01) begin
						step_cyc = raw_cyc(22'(r.base), {8'h00, flash_cmd_pkg::CMD_BUF_COMMIT});
					end else if (r.step == 5'h04) begin
						step_cyc = raw_cyc(22'(buf_addr_i), 16'(buf_data_i));
					end else begin
						step_cyc = raw_cyc(22'(page_addr), 16'(buf_data_i));
					end
				end else if (r.op == flash_cmd_pkg::OP_CHIP_ERASE) begin
					step_cyc = cmd_cyc(flash_cmd_pkg::UNLOCK_ADDR_A, flash_cmd_pkg::CMD_CHIP_ERASE);
				end else if (r.op == flash_cmd_pkg::OP_SECTOR_ERASE) begin
					step_cyc = raw_cyc({r.base[21:flash_cmd_pkg::SECTOR_LSB], 15'h0000},
						{8'h00, flash_cmd_pkg::CMD_SECTOR_ERASE});
				end
			end
		endcase
	end

	// word request pulses in the hold cycle of each buffer word step
	logic buf_word_step;
	assign buf_word_step = r.op == flash_cmd_pkg::OP_BUF_PROGRAM && r.step > 5'h03 &&
		r.step < r.last - 5'h01;

	always_comb begin
		next_r = r;
		next_r.rvalid = 1'b0;
		if (r.win != 32'h0) next_r.win = r.win - 32'h1;
		unique case (r.st)
			ST_IDLE: begin
				if (cmd_valid_i) begin
					next_r.op = cmd_op_i;
					next_r.base = cmd_addr_i;
					next_r.wdata = cmd_data_i;
					next_r.count = cmd_count_i;
					next_r.step = 5'h00;
					// bypass level held for the whole op so length and steps agree
					next_r.byp = cmd_in_bypass_i;
					next_r.last = seq_len(cmd_op_i,
						(cmd_count_i > COUNT_W'(flash_cmd_pkg::MAX_BUF_WORDS - 1)) ?
						5'(flash_cmd_pkg::MAX_BUF_WORDS - 1) : 5'(cmd_count_i), cmd_in_bypass_i);
					next_r.st = ST_SETUP;
					if (cmd_op_i != flash_cmd_pkg::OP_READ && cmd_op_i != flash_cmd_pkg::OP_SUSPEND &&
						cmd_op_i != flash_cmd_pkg::OP_SECTOR_ERASE) next_r.win = 32'h0;
				end
			end
			ST_SETUP: begin
				next_r.cur = step_cyc;
				next_r.is_read = step_is_read;
				if (buf_word_step && r.step == 5'h04) next_r.page = buf_addr_i;
				next_r.tick = 4'h0;
				next_r.st = step_is_read ? ST_READ : ST_STROBE;
			end
			ST_STROBE: begin
				next_r.tick = r.tick + 4'h1;
				// address latched at falling, data at rising strobe edge
				if (r.tick == 4'(flash_cmd_pkg::STROBE_CYC - 1)) next_r.st = ST_HOLD;
			end
			ST_READ: begin
				// data sampled in the last cycle of the access window
				next_r.tick = r.tick + 4'h1;
				if (r.tick == 4'(flash_cmd_pkg::ACCESS_CYC - 1)) begin
					next_r.rdata = flash_dq_i;
					next_r.st = ST_HOLD;
				end
			end
			ST_HOLD: begin
				next_r.step = r.step + 5'h01;
				next_r.st = (r.step + 5'h01 == r.last) ? ST_DONE : ST_SETUP;
			end
			ST_DONE: begin
				next_r.rvalid = 1'b1;
				if (r.op == flash_cmd_pkg::OP_SECTOR_ERASE)
					next_r.win = 32'(ERASE_WINDOW_CYCLES);
				if (r.op == flash_cmd_pkg::OP_SUSPEND) next_r.win = 32'h0;
				next_r.st = ST_IDLE;
			end
			default: next_r.st = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	// handshake and pin strobes decode from the state register
	assign cmd_ready_o = r.st == ST_IDLE;
	assign buf_word_req_o = buf_word_step && r.st == ST_HOLD;
	assign rsp_valid_o = r.rvalid;
	assign rsp_data_o = r.rdata;
	assign rsp_status_o.timeout_error_bit = r.rdata[flash_cmd_pkg::TIMEOUT_ERR_POS];
	assign rsp_status_o.polling_bit = r.rdata[flash_cmd_pkg::POLLING_POS];
	assign rsp_status_o.toggle_bit_one = r.rdata[flash_cmd_pkg::TOGGLE_ONE_POS];
	assign rsp_status_o.toggle_bit_two = r.rdata[flash_cmd_pkg::TOGGLE_TWO_POS];
	assign rsp_status_o.erase_window_bit = r.rdata[flash_cmd_pkg::ERASE_WINDOW_POS];
	assign device_busy_o = ~ready_busy_out_i;
	assign erase_window_open_o = r.win != 32'h0;
	assign flash_addr_o = ADDR_W'(r.cur.addr);
	assign flash_dq_o = DATA_W'(r.cur.data);
	assign flash_dq_oe_o = r.st == ST_STROBE || (r.st == ST_HOLD && !r.is_read);
	assign flash_ce_n_o = !(r.st == ST_STROBE || r.st == ST_READ);
	assign flash_we_n_o = r.st != ST_STROBE;
	assign flash_oe_n_o = r.st != ST_READ;
endmodule

// ### verification/flash_host_ctrl_props.sv
// port assertions for the flash host controller
module flash_host_ctrl_props (
	// watched ports
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic cmd_ready_o,
	input wire logic buf_word_req_o,
	input wire logic rsp_valid_o,
	input wire logic device_busy_o,
	input wire logic ready_busy_out_i,
	input wire logic [21:0] flash_addr_o,
	input wire logic [15:0] flash_dq_o,
	input wire logic flash_dq_oe_o,
	input wire logic flash_ce_n_o,
	input wire logic flash_we_n_o,
	input wire logic flash_oe_n_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	unlock_bits_a: assert property (
		!flash_we_n_o && flash_addr_o[10:0] == 11'h555 && flash_dq_o[7:0] == 8'hAA
		|-> flash_addr_o[21:11] == 11'h000 && flash_dq_o[15:8] == 8'h00) else $error("unlock high bits");
	strobe_len_a: assert property (
		$fell(flash_we_n_o) |-> !flash_we_n_o [*5] ##1 flash_we_n_o) else $error("write strobe length");
	strobe_hold_a: assert property (
		!flash_we_n_o && !$past(flash_we_n_o) |-> $stable(flash_dq_o) && $stable(flash_addr_o))
		else $error("write data moved");
	write_drive_a: assert property (
		!flash_we_n_o |-> flash_dq_oe_o && !flash_ce_n_o && flash_oe_n_o) else $error("write pins");
	read_len_a: assert property (
		$fell(flash_oe_n_o) |-> !flash_dq_oe_o ##9 !flash_oe_n_o ##1 flash_oe_n_o)
		else $error("read strobe length");
	read_answer_a: assert property (
		$rose(flash_oe_n_o) |-> ##[1:3] rsp_valid_o) else $error("read without answer");
	busy_map_a: assert property (
		device_busy_o == !ready_busy_out_i) else $error("busy mismatch");
	answer_pulse_a: assert property (
		rsp_valid_o |=> !rsp_valid_o && cmd_ready_o) else $error("answer not a pulse");
	buf_pulse_a: assert property (
		buf_word_req_o |=> !buf_word_req_o) else $error("word request too long");
	reset_idle_a: assert property (
		$fell(rst_i) |-> flash_ce_n_o && flash_we_n_o && flash_oe_n_o && !flash_dq_oe_o
		&& cmd_ready_o && !rsp_valid_o) else $error("not idle after reset");
endmodule
bind flash_host_ctrl flash_host_ctrl_props props (.clk_sys_i, .rst_i, .cmd_ready_o,
	.buf_word_req_o, .rsp_valid_o, .device_busy_o, .ready_busy_out_i, .flash_addr_o,
	.flash_dq_o, .flash_dq_oe_o, .flash_ce_n_o, .flash_we_n_o, .flash_oe_n_o);

// ### verification/flash_dev_model.sv
// behavioural flash device behind the controller pins
module flash_dev_model #(
	parameter logic [15:0] MAKER_CODE = 16'h00A5, // arbitrary
	parameter logic [15:0] DEV_CODE = 16'h1230 // arbitrary
) (
	// pins
	input wire logic rst_i,
	input wire logic [21:0] addr_i,
	input wire logic [15:0] dq_i,
	input wire logic ce_n_i,
	input wire logic we_n_i,
	input wire logic oe_n_i,
	output logic [15:0] dq_o,
	output logic ready_busy_out_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] mem [256];
	logic [15:0] rd;
	logic [3:0] st;
	logic [4:0] left;
	logic ident, byp;
	wire [10:0] a = addr_i[10:0];
	wire [7:0] d = dq_i[7:0];
	initial ready_busy_out_o = 1'h1;
	initial foreach (mem[i]) mem[i] = 16'hFFFF;
	always_comb begin
		rd = mem[addr_i[7:0]];
		if (ident) case (addr_i[7:0])
			8'h00: rd = MAKER_CODE;
			8'h01, 8'h0E, 8'h0F: rd = DEV_CODE | 16'(addr_i[3:0]);
			8'h02: rd = 16'(addr_i[15]);
			8'h03: rd = 16'h0098;
			default: rd = 16'h0000;
		endcase
	end
	// released bus shows the inverted addressed word
	assign dq_o = (!ce_n_i && !oe_n_i) ? rd : ~rd;
	always @(posedge we_n_i or posedge rst_i) begin
		if (rst_i) begin
			st = 0;
			ident = 0;
			byp = 0;
		end else if (st == 4) begin
			mem[a[7:0]] = dq_i;
			st = 0;
			fork
				begin
					ready_busy_out_o = 0;
					#200 ready_busy_out_o = 1;
				end
			join_none
		end else if (st == 9 && left != 0) begin
			mem[a[7:0]] = dq_i;
			left--;
		end else if (d == 8'hF0) begin
			st = 0;
			ident = 0;
		end else case (st)
			0: if (byp && d == 8'hA0) st = 4;
				else if (byp && d == 8'h90) st = 10;
				else if (ident && d == 8'h00) ident = 0;
				else if (a == 11'h555 && d == 8'hAA) st = 1;
			1: st = (a == 11'h2AA && d == 8'h55) ? 2 : 0;
			2: begin
				st = (d == 8'hA0) ? 4 : (d == 8'h80) ? 5 : (d == 8'h25) ? 8 : 0;
				if (d == 8'h90) ident = 1;
				if (d == 8'h20) byp = 1;
			end
			5: st = (d == 8'hAA) ? 6 : 0;
			6: st = (d == 8'h55) ? 7 : 0;
			7: begin
				if (d == 8'h10 || d == 8'h30) foreach (mem[i]) mem[i] = 16'hFFFF;
				st = 0;
			end
			8: begin
				left = dq_i[4:0] + 5'h1;
				st = 9;
			end
			10: begin
				if (d == 8'h00) byp = 0;
				st = 0;
			end
			default: st = 0;
		endcase
	end
endmodule

// ### verification/flash_host_ctrl_bench.sv
// self-checking bench for the flash host controller
module flash_host_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys_i = 1'h0, rst_i = 1'h1, cmd_valid_i = 1'h0, cmd_in_bypass_i = 1'h0;
	flash_cmd_pkg::op_t cmd_op_i = flash_cmd_pkg::OP_READ;
	logic [21:0] cmd_addr_i = 22'h0, flash_addr_o, buf_addr_i;
	logic [15:0] cmd_data_i = 16'h0, buf_data_i, flash_dq_i, flash_dq_o, rsp_data_o, dev_dq;
	logic [4:0] cmd_count_i = 5'h0;
	logic cmd_ready_o, buf_word_req_o, rsp_valid_o, device_busy_o, erase_window_open_o;
	logic flash_dq_oe_o, flash_ce_n_o, flash_we_n_o, flash_oe_n_o, ready_busy_out_i;
	flash_cmd_pkg::status_t rsp_status_o;
	int errors = 0, n_compared = 0, bi = 0;
	logic [21:0] ia [7] = '{22'h0, 22'h1, 22'hE, 22'hF, 22'h3, 22'h8002, 22'h2};
	logic [15:0] ie [7] = '{16'h00A5, 16'h1231, 16'h123E, 16'h123F, 16'h0098, 16'h0001, 16'h0};
	flash_cmd_pkg::op_t mo [5] = '{flash_cmd_pkg::OP_BUF_ABORT, flash_cmd_pkg::OP_SUSPEND,
		flash_cmd_pkg::OP_RESUME, flash_cmd_pkg::OP_QUERY, flash_cmd_pkg::OP_RESET};
	always #5 clk_sys_i = ~clk_sys_i;
	assign buf_addr_i = 22'h40 + 22'(bi);
	assign buf_data_i = 16'h3C00 + 16'(bi);
	assign flash_dq_i = flash_dq_oe_o ? flash_dq_o : dev_dq;
	always @(negedge clk_sys_i) if (buf_word_req_o === 1'h1) bi++;
	flash_host_ctrl #(.ERASE_WINDOW_CYCLES(20)) dut (.clk_sys_i, .rst_i, .cmd_valid_i,
		.cmd_ready_o, .cmd_op_i, .cmd_addr_i, .cmd_data_i, .cmd_count_i, .cmd_in_bypass_i,
		.buf_word_req_o, .buf_addr_i, .buf_data_i, .rsp_valid_o, .rsp_data_o, .rsp_status_o,
		.device_busy_o, .erase_window_open_o, .flash_addr_o, .flash_dq_i, .flash_dq_o,
		.flash_dq_oe_o, .flash_ce_n_o, .flash_we_n_o, .flash_oe_n_o, .ready_busy_out_i);
	flash_dev_model dev (.rst_i, .addr_i(flash_addr_o), .dq_i(flash_dq_i), .ce_n_i(flash_ce_n_o),
		.we_n_i(flash_we_n_o), .oe_n_i(flash_oe_n_o), .dq_o(dev_dq),
		.ready_busy_out_o(ready_busy_out_i));
	task automatic conclude();
		if (errors == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic check(string n, logic [15:0] e, logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic op(flash_cmd_pkg::op_t o, logic [21:0] a, logic [15:0] d = 16'h0,
		logic [4:0] c = 5'h0);
		int i;
		@(negedge clk_sys_i);
		cmd_op_i = o;
		cmd_addr_i = a;
		cmd_data_i = d;
		cmd_count_i = c;
		cmd_valid_i = 1'h1;
		for (i = 0; i < 400 && rsp_valid_o !== 1'h1; i++) begin
			@(negedge clk_sys_i);
			if (cmd_ready_o === 1'h0) cmd_valid_i = 1'h0;
		end
		cmd_valid_i = 1'h0;
		if (i == 400) begin
			errors++;
			conclude();
		end
	endtask
	task automatic rd_chk(string n, logic [21:0] a, logic [15:0] e);
		op(flash_cmd_pkg::OP_READ, a);
		check(n, e, rsp_data_o);
	endtask
	initial begin
		repeat (5) @(posedge clk_sys_i);
		@(negedge clk_sys_i) rst_i = 1'h0;
		rd_chk("erased word", 22'h12, 16'hFFFF);
		op(flash_cmd_pkg::OP_PROGRAM, 22'h3F0012, 16'hA5C3);
		check("busy", 16'h1, 16'(device_busy_o));
		rd_chk("programmed word", 22'h12, 16'hA5C3);
		check("program status", 16'h000C, 16'(rsp_status_o));
		for (int k = 0; k < 7; k++) begin
			op(flash_cmd_pkg::OP_IDENT, ia[k]);
			check("ident word", ie[k], rsp_data_o);
		end
		op(flash_cmd_pkg::OP_RESET, 22'h7);
		rd_chk("read after reset", 22'h12, 16'hA5C3);
		op(flash_cmd_pkg::OP_IDENT, 22'h0);
		op(flash_cmd_pkg::OP_REGION_ENTER, 22'h0);
		op(flash_cmd_pkg::OP_REGION_EXIT, 22'h0);
		rd_chk("read after exit", 22'h12, 16'hA5C3);
		op(flash_cmd_pkg::OP_IDENT, 22'h0);
		rst_i = 1'h1;
		repeat (2) @(negedge clk_sys_i);
		rst_i = 1'h0;
		rd_chk("read after reset pin", 22'h12, 16'hA5C3);
		op(flash_cmd_pkg::OP_BUF_PROGRAM, 22'h40, 16'h0, 5'h1);
		rd_chk("buffer word 0", 22'h40, 16'h3C00);
		rd_chk("buffer word 1", 22'h41, 16'h3C01);
		op(flash_cmd_pkg::OP_BYPASS_ENTER, 22'h0);
		cmd_in_bypass_i = 1'h1;
		op(flash_cmd_pkg::OP_PROGRAM, 22'h20, 16'h5A0F);
		op(flash_cmd_pkg::OP_BYPASS_PROGRAM, 22'h21, 16'h6B1E);
		op(flash_cmd_pkg::OP_BYPASS_EXIT, 22'h0);
		cmd_in_bypass_i = 1'h0;
		rd_chk("bypass word", 22'h20, 16'h5A0F);
		check("bypass status", 16'h0003, 16'(rsp_status_o));
		rd_chk("bypass op word", 22'h21, 16'h6B1E);
		foreach (mo[k]) op(mo[k], 22'h0);
		rd_chk("read after misc", 22'h12, 16'hA5C3);
		op(flash_cmd_pkg::OP_CHIP_ERASE, 22'h0);
		rd_chk("chip erased", 22'h12, 16'hFFFF);
		op(flash_cmd_pkg::OP_PROGRAM, 22'h8012, 16'h0F0F);
		op(flash_cmd_pkg::OP_SECTOR_ERASE, 22'h8000);
		check("window open", 16'h1, 16'(erase_window_open_o));
		repeat (25) @(negedge clk_sys_i);
		check("window closed", 16'h0, 16'(erase_window_open_o));
		rd_chk("sector erased", 22'h8012, 16'hFFFF);
		conclude();
	end
endmodule
